// ==== pkg/sfm_pkg.sv ====
// shared constants for the serial memory link ends
package sfm_pkg;
   localparam int          ADDR_W        = 18;
   localparam int          DEPTH_BYTES   = 262144;
   localparam logic [17:0] ADDR_TOP      = 18'h3FFFF;
   // command codes
   localparam logic [7:0]  OP_READ       = 8'h03;
   localparam logic [7:0]  OP_LAT_READ   = 8'h0B;
   localparam logic [7:0]  OP_WRITE      = 8'h02;
   localparam logic [7:0]  OP_SLEEP      = 8'hB9;
   localparam logic [7:0]  OP_IDENTIFY   = 8'h9F;
   // identification values, all arbitrary
   localparam logic [7:0]  ID_CONT       = 8'h5A;
   localparam logic [7:0]  ID_MAKER      = 8'h3C;
   localparam logic [2:0]  ID_FAMILY     = 3'h2;
   localparam logic [4:0]  ID_DENSITY    = 5'h0A;
   localparam logic [1:0]  ID_SUB        = 2'h1;
   localparam logic [2:0]  ID_REV        = 3'h3;
   localparam logic [2:0]  ID_RSVD       = 3'h0;
   localparam logic [3:0]  ID_CONT_BYTES = 4'h6;
   localparam logic [3:0]  ID_LEN        = 4'h9;
   // timing
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          REC_TIME_US   = 450;
   localparam int          REC_CYC       = (REC_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int          DESEL_TIME_NS = 60;
   localparam int          DESEL_CYC     = (DESEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0]  SCK_HALF_CYC  = 2'h3;
   localparam int          WFIFO_DEPTH   = 16;
endpackage

// ==== pkg/sfm_link_if.sv ====
// serial link between memory master and memory slave
`timescale 1ns/10ps
`default_nettype none
interface sfm_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe_n;
   // pulled-up line when the slave releases it
   wire  so_line = so_oe_n ? 1'b1 : so;
   modport dev  (input cs_n, input sck, input si, output so, output so_oe_n);
   modport host (output cs_n, output sck, output si, input so_line);
endinterface
`default_nettype wire

// ==== hdl/sfm_fifo.sv ====
// parameterised byte fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sfm_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   // fill side
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   // drain side
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [0:D-1];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic [AW:0]   cnt_nxt;
   wire           push_w = in_valid_i & in_ready_o;
   wire           pop_w  = out_valid_o & out_ready_i;

   assign out_valid_o = cnt_r != '0;
   assign out_data_o  = mem_r[rp_r];
   assign cnt_nxt     = cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);

   always_ff @(posedge clk_i) begin
      if (push_w) begin
         mem_r[wp_r] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wp_r       <= '0;
         rp_r       <= '0;
         cnt_r      <= '0;
         in_ready_o <= 1'b0;
      end else begin
         wp_r       <= wp_r + AW'(push_w);
         rp_r       <= rp_r + AW'(pop_w);
         cnt_r      <= cnt_nxt;
         in_ready_o <= cnt_nxt != (AW+1)'(D);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/sfm_device.sv ====
// serial memory slave: read, latency read, write, sleep, identify
// Operation
// (RULE_01) command then three address bytes, 18 bits used
// (RULE_02) data out on following clocks, input ignored
// (RULE_03) read address increments, wraps to zero
// (RULE_04) read bytes leave msb first
// (RULE_05) select rise ends read, output released
// (RULE_06) latency read adds one dummy byte
// (RULE_07) latency read streams, wraps, released on deselect
// (RULE_08) sleep entered after code and deselect
// (RULE_09) asleep: clock, input ignored, output released
// (RULE_10) select fall starts wake, commands dropped
// (RULE_11) master issues throwaway select, then waits
// (RULE_12) identify returns maker then product codes
// (RULE_13) identify response is nine bytes long
// (RULE_14) product field layout family density sub rev
// (RULE_15) each write byte stored when complete
// (RULE_16) wake recovery at most 450 microseconds
// (RULE_17) clock modes 0 and 3, rising sample
// (RULE_18) every deselect returns decoder to idle; here D_SLPARM goes to D_SLEEP and D_SLEEP, D_WAKE ignore deselect
// (RULE_19) unknown command ignored, output released
`timescale 1ns/10ps
`default_nettype none
module sfm_device
   import sfm_pkg::*;
#(
   parameter int REC_CYCLES = REC_CYC
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // link
   sfm_link_if.dev   link,
   // status
   output logic      asleep_o,
   output logic      busy_o
);
   typedef enum logic [3:0] {
      D_IDLE   = 4'h0,
      D_CMD    = 4'h1,
      D_ADDR   = 4'h3,
      D_DUMMY  = 4'h2,
      D_RDAT   = 4'h6,
      D_WDAT   = 4'h7,
      D_IDENT  = 4'h5,
      D_SLPARM = 4'h4,
      D_SLEEP  = 4'hC,
      D_WAKE   = 4'hD,
      D_SKIP   = 4'hF
   } sfm_dst_e;

   logic [7:0]  mem_r [0:DEPTH_BYTES-1];
   sfm_dst_e    st_r;
   logic [2:0]  cs_q;
   logic [2:0]  sck_q;
   logic [1:0]  si_q;
   logic [2:0]  bit_r;
   logic [6:0]  sr_r;
   logic [17:0] addr_r;
   logic [1:0]  acnt_r;
   logic        fast_r;
   logic        wr_r;
   logic [7:0]  tx_r;
   logic        oe_n_r;
   logic [3:0]  idx_r;
   logic [13:0] rec_r;

   function automatic logic [17:0] next_addr(input logic [17:0] a);
      next_addr = (a == ADDR_TOP) ? 18'h00000 : a + 18'h00001;
   endfunction

   function automatic logic [7:0] id_byte(input logic [3:0] i);
      if (i < ID_CONT_BYTES) begin
         id_byte = ID_CONT;
      end else if (i == ID_CONT_BYTES) begin
         id_byte = ID_MAKER;
      end else if (i == ID_CONT_BYTES + 4'h1) begin
         id_byte = {ID_FAMILY, ID_DENSITY};
      end else begin
         id_byte = {ID_SUB, ID_REV, ID_RSVD};
      end
   endfunction

   // synchronised pins and edges
   wire         cs_s      = cs_q[1];
   wire         cs_fall   = cs_q[2] & ~cs_q[1];
   wire         cs_rise   = ~cs_q[2] & cs_q[1];
   wire         sck_rise  = ~sck_q[2] & sck_q[1] & ~cs_s;
   wire         byte_done = sck_rise & (bit_r == 3'h7);
   wire [7:0]   byte_w    = {sr_r, si_q[1]};
   wire [17:0]  full_addr = {addr_r[9:0], byte_w};
   wire         addr_last = (st_r == D_ADDR) & byte_done & (acnt_r == 2'h2);
   wire [17:0]  ld_addr   = (st_r == D_ADDR) ? full_addr :
                            (st_r == D_RDAT) ? next_addr(addr_r) : addr_r;
   wire [7:0]   ld_byte   = mem_r[ld_addr];
   wire [3:0]   idx_nxt   = idx_r + 4'h1;

   assign link.so      = tx_r[7];
   assign link.so_oe_n = oe_n_r;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         cs_q  <= 3'h7;
         sck_q <= 3'h0;
         si_q  <= 2'h0;
      end else begin
         cs_q  <= {cs_q[1:0], link.cs_n};
         sck_q <= {sck_q[1:0], link.sck};
         si_q  <= {si_q[0], link.si};
      end
   end

   // array write only on a whole byte
   always_ff @(posedge clk_i) begin
      if (st_r == D_WDAT && byte_done && !cs_rise) begin
         mem_r[addr_r] <= byte_w; // [RULE_15]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_r     <= D_IDLE;
         bit_r    <= 3'h0;
         sr_r     <= 7'h00;
         addr_r   <= 18'h00000;
         acnt_r   <= 2'h0;
         fast_r   <= 1'b0;
         wr_r     <= 1'b0;
         tx_r     <= 8'h00;
         oe_n_r   <= 1'b1;
         idx_r    <= 4'h0;
         rec_r    <= 14'h0000;
         asleep_o <= 1'b0;
         busy_o   <= 1'b0;
      end else begin
         busy_o <= ~cs_s;
         if (sck_rise) begin
            bit_r <= bit_r + 3'h1; // [RULE_17]
            sr_r  <= byte_w[6:0];
         end
         unique case (st_r)
            D_SLEEP: begin
               if (cs_fall) begin // [RULE_09]
                  st_r     <= D_WAKE; // [RULE_10]
                  rec_r    <= 14'h0000;
                  asleep_o <= 1'b0;
               end
            end
            D_WAKE: begin
               rec_r <= rec_r + 14'h0001;
               if (rec_r == 14'(REC_CYCLES - 1)) begin
                  st_r <= cs_s ? D_IDLE : D_SKIP; // [RULE_16]
               end
            end
            default: begin
               if (cs_rise) begin
                  oe_n_r <= 1'b1; // [RULE_05] [RULE_07]
                  bit_r  <= 3'h0;
                  if (st_r == D_SLPARM) begin
                     st_r     <= D_SLEEP; // [RULE_08]
                     asleep_o <= 1'b1;
                  end else begin
                     st_r <= D_IDLE; // [RULE_18]
                  end
               end else if (st_r == D_IDLE) begin
                  if (cs_fall) begin
                     st_r  <= D_CMD;
                     bit_r <= 3'h0;
                  end
               end else if (byte_done) begin
                  unique case (st_r)
                     D_CMD: begin
                        acnt_r <= 2'h0;
                        fast_r <= byte_w == OP_LAT_READ;
                        wr_r   <= byte_w == OP_WRITE;
                        idx_r  <= 4'h0;
                        if (byte_w == OP_READ || byte_w == OP_LAT_READ ||
                            byte_w == OP_WRITE) begin
                           st_r <= D_ADDR;
                        end else if (byte_w == OP_SLEEP) begin
                           st_r <= D_SLPARM;
                        end else if (byte_w == OP_IDENTIFY) begin
                           st_r   <= D_IDENT; // [RULE_12]
                           tx_r   <= id_byte(4'h0);
                           oe_n_r <= 1'b0;
                        end else begin
                           st_r <= D_SKIP; // [RULE_19]
                        end
                     end
                     D_ADDR: begin
                        acnt_r <= acnt_r + 2'h1;
                        addr_r <= full_addr; // [RULE_01]
                        if (addr_last) begin
                           if (fast_r) begin
                              st_r <= D_DUMMY; // [RULE_06]
                           end else if (wr_r) begin
                              st_r <= D_WDAT;
                           end else begin
                              st_r   <= D_RDAT; // [RULE_02]
                              tx_r   <= ld_byte;
                              oe_n_r <= 1'b0;
                           end
                        end
                     end
                     D_DUMMY: begin
                        st_r   <= D_RDAT; // [RULE_06]
                        tx_r   <= ld_byte;
                        oe_n_r <= 1'b0;
                     end
                     D_RDAT: begin
                        addr_r <= ld_addr; // [RULE_03] [RULE_07]
                        tx_r   <= ld_byte;
                     end
                     D_WDAT: begin
                        addr_r <= next_addr(addr_r);
                     end
                     D_IDENT: begin
                        idx_r <= idx_nxt;
                        if (idx_nxt == ID_LEN) begin
                           st_r   <= D_SKIP; // [RULE_13]
                           oe_n_r <= 1'b1;
                        end else begin
                           tx_r <= id_byte(idx_nxt); // [RULE_14]
                        end
                     end
                     default: begin
                     end
                  endcase
               end else if (sck_rise && (st_r == D_RDAT || st_r == D_IDENT)) begin
                  tx_r <= {tx_r[6:0], 1'b0}; // [RULE_04]
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== hdl/sfm_host.sv ====
// serial memory master: frames commands, wakes a sleeping slave
`timescale 1ns/10ps
`default_nettype none
module sfm_host
   import sfm_pkg::*;
#(
   parameter int REC_CYCLES = REC_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // command
   input  wire logic        start_i,
   input  wire logic [7:0]  op_i,
   input  wire logic [17:0] addr_i,
   input  wire logic [15:0] len_i,
   output logic             busy_o,
   // write data
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        wr_valid_i,
   output logic             wr_ready_o,
   // read data
   output logic [7:0]       rd_data_o,
   output logic             rd_valid_o,
   // link
   sfm_link_if.host         link
);
   typedef enum logic [2:0] {
      H_IDLE  = 3'h0,
      H_SEL   = 3'h1,
      H_SHIFT = 3'h3,
      H_STALL = 3'h2,
      H_END   = 3'h6,
      H_WCS   = 3'h4,
      H_WAIT  = 3'h5
   } sfm_hst_e;

   sfm_hst_e    st_r;
   logic [1:0]  so_q;
   logic [1:0]  div_r;
   logic        sck_r;
   logic        cs_n_r;
   logic        si_r;
   logic [7:0]  tx_r;
   logic [7:0]  rx_r;
   logic [2:0]  bit_r;
   logic [31:0] hdr_r;
   logic [2:0]  hcnt_r;
   logic [15:0] dcnt_r;
   logic        data_r;
   logic [7:0]  op_r;
   logic        asleep_r;
   logic [13:0] rec_r;
   logic [7:0]  f_data;
   logic        f_valid;

   wire tick     = div_r == SCK_HALF_CYC;
   wire fall_w   = (st_r == H_SHIFT) & tick & sck_r;
   wire rise_w   = (st_r == H_SHIFT) & tick & ~sck_r;
   wire byte_end = fall_w & (bit_r == 3'h7);
   wire is_wr    = op_r == OP_WRITE;
   wire need_wr  = (hcnt_r == 3'h0) & (dcnt_r != 16'h0000) & is_wr;
   wire pop_w    = f_valid & ((byte_end & need_wr) | (st_r == H_STALL));
   wire has_addr = op_i == OP_READ || op_i == OP_LAT_READ || op_i == OP_WRITE;

   sfm_fifo #(.W(8), .D(WFIFO_DEPTH)) u_wfifo (
      .clk_i       (clk_i),
      .rstn_i      (rstn_i),
      .in_data_i   (wr_data_i),
      .in_valid_i  (wr_valid_i),
      .in_ready_o  (wr_ready_o),
      .out_data_o  (f_data),
      .out_valid_o (f_valid),
      .out_ready_i (pop_w)
   );

   assign link.cs_n = cs_n_r;
   assign link.sck  = sck_r;
   assign link.si   = si_r;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         so_q <= 2'h0;
      end else begin
         so_q <= {so_q[0], link.so_line};
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_r       <= H_IDLE;
         div_r      <= 2'h0;
         sck_r      <= 1'b0;
         cs_n_r     <= 1'b1;
         si_r       <= 1'b0;
         tx_r       <= 8'h00;
         rx_r       <= 8'h00;
         bit_r      <= 3'h0;
         hdr_r      <= 32'h00000000;
         hcnt_r     <= 3'h0;
         dcnt_r     <= 16'h0000;
         data_r     <= 1'b0;
         op_r       <= 8'h00;
         asleep_r   <= 1'b0;
         rec_r      <= 14'h0000;
         busy_o     <= 1'b0;
         rd_data_o  <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= 1'b0;
         div_r      <= tick ? 2'h0 : div_r + 2'h1;
         unique case (st_r)
            H_IDLE: begin
               div_r <= 2'h0;
               if (start_i) begin
                  busy_o <= 1'b1;
                  op_r   <= op_i;
                  hdr_r  <= {6'h00, addr_i, 8'h00};
                  hcnt_r <= (op_i == OP_LAT_READ) ? 3'h4 : has_addr ? 3'h3 : 3'h0;
                  dcnt_r <= (op_i == OP_SLEEP) ? 16'h0000 : len_i;
                  st_r   <= asleep_r ? H_WCS : H_SEL;
                  cs_n_r <= ~asleep_r;
               end
            end
            H_WCS: begin
               // throwaway select that starts the wake [RULE_11]
               if (tick) begin
                  cs_n_r   <= 1'b1;
                  asleep_r <= 1'b0;
                  rec_r    <= 14'h0000;
                  st_r     <= H_WAIT;
               end
            end
            H_WAIT: begin
               rec_r <= rec_r + 14'h0001;
               if (rec_r == 14'(REC_CYCLES - 1)) begin
                  st_r   <= H_SEL; // [RULE_11]
                  cs_n_r <= 1'b0;
               end
            end
            H_SEL: begin
               cs_n_r <= 1'b0;
               tx_r   <= op_r;
               si_r   <= op_r[7];
               bit_r  <= 3'h0;
               data_r <= 1'b0;
               if (tick) begin
                  st_r <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  sck_r <= ~sck_r; // [RULE_17]
               end
               if (rise_w) begin
                  rx_r <= {rx_r[6:0], so_q[1]};
               end
               if (fall_w) begin
                  bit_r <= bit_r + 3'h1;
                  if (bit_r != 3'h7) begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     si_r <= tx_r[6];
                  end
               end
               if (byte_end) begin
                  if (data_r && !is_wr) begin
                     rd_data_o  <= rx_r;
                     rd_valid_o <= 1'b1;
                  end
                  if (hcnt_r != 3'h0) begin
                     hcnt_r <= hcnt_r - 3'h1; // [RULE_01] [RULE_06]
                     hdr_r  <= {hdr_r[23:0], 8'h00};
                     tx_r   <= hdr_r[31:24];
                     si_r   <= hdr_r[31];
                  end else if (dcnt_r != 16'h0000) begin
                     dcnt_r <= dcnt_r - 16'h0001;
                     data_r <= 1'b1;
                     if (!is_wr) begin
                        tx_r <= 8'h00;
                        si_r <= 1'b0;
                     end else if (f_valid) begin
                        tx_r <= f_data;
                        si_r <= f_data[7];
                     end else begin
                        st_r <= H_STALL;
                     end
                  end else begin
                     st_r <= H_END;
                  end
               end
            end
            H_STALL: begin
               div_r <= 2'h0;
               if (f_valid) begin
                  tx_r <= f_data;
                  si_r <= f_data[7];
                  st_r <= H_SHIFT;
               end
            end
            H_END: begin
               cs_n_r <= 1'b1;
               if (tick) begin
                  st_r   <= H_IDLE;
                  busy_o <= 1'b0;
                  if (op_r == OP_SLEEP) begin
                     asleep_r <= 1'b1; // [RULE_08]
                  end
               end
            end
            default: begin
               st_r <= H_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== testbench/sfm_link_checker.sv ====
// concurrent checks on the serial link between the two ends
`timescale 1ns/10ps
`default_nettype none
module sfm_link_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic so_oe_n,
   // slave status
   input wire logic asleep_o
);
   logic        sck_r;
   logic [15:0] rises_r;
   logic [15:0] rises_nxt;
   wire         sck_rise = sck & ~sck_r;

   // serial clock rises counted inside the current frame
   assign rises_nxt = cs_n ? 16'h0000 : rises_r + {15'h0000, sck_rise};

   always_ff @(posedge clk_i) begin
      sck_r   <= rstn_i ? sck : 1'b0;
      rises_r <= rstn_i ? rises_nxt : 16'h0000;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_release_on_deselect;
      $rose(cs_n) |-> ##[1:5] so_oe_n;
   endproperty
   a_release_on_deselect: assert property (p_release_on_deselect)
      else $error("output still driven after deselect");

   property p_whole_bytes;
      $rose(cs_n) |-> (rises_r[2:0] == 3'h0);
   endproperty
   a_whole_bytes: assert property (p_whole_bytes)
      else $error("frame ended on a partial byte");

   property p_drive_after_header;
      $fell(so_oe_n) |-> (rises_r == 16'h0008 || rises_r == 16'h0020 || rises_r == 16'h0028);
   endproperty
   a_drive_after_header: assert property (p_drive_after_header)
      else $error("output driven at a wrong bit count");

   property p_idle_mode0;
      cs_n |-> !sck;
   endproperty
   a_idle_mode0: assert property (p_idle_mode0)
      else $error("serial clock high while deselected");

   property p_deselect_gap;
      $rose(cs_n) |-> cs_n [*3];
   endproperty
   a_deselect_gap: assert property (p_deselect_gap)
      else $error("deselect gap too short");

   property p_sleep_released;
      asleep_o |-> so_oe_n;
   endproperty
   a_sleep_released: assert property (p_sleep_released)
      else $error("output driven while asleep");

   property p_sleep_entry;
      $rose(asleep_o) |-> cs_n && $past(cs_n, 2);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep entered while selected");

   property p_sleep_holds;
      asleep_o && cs_n && $past(cs_n, 4) |=> asleep_o;
   endproperty
   a_sleep_holds: assert property (p_sleep_holds)
      else $error("sleep left without a select fall");

   // recovery set to 20 cycles in the bench, plus sync delay
   property p_wake_bound;
      asleep_o && $fell(cs_n) |-> ##[1:40] !asleep_o;
   endproperty
   a_wake_bound: assert property (p_wake_bound)
      else $error("wake-up took too long");

   c_lat_read: cover property ($fell(so_oe_n) && rises_r == 16'h0028);
   c_identify: cover property ($fell(so_oe_n) && rises_r == 16'h0008);
   c_sleep: cover property ($rose(asleep_o));
endmodule
`default_nettype wire

// ==== testbench/spi_memory_read_sleep_id_test.sv ====
// self-checking bench joining the memory master and slave
`timescale 1ns/10ps
`default_nettype none
module spi_memory_read_sleep_id_test;
   import sfm_pkg::*;
   localparam int REC   = 20;
   localparam int LIMIT = 40000;
   logic        clk_i      = 1'b0;
   logic        rstn_i     = 1'b0;
   logic        start_i    = 1'b0;
   logic [7:0]  op_i       = 8'h00;
   logic [17:0] addr_i     = 18'h00000;
   logic [15:0] len_i      = 16'h0000;
   logic [7:0]  wr_data_i  = 8'h00;
   logic        wr_valid_i = 1'b0;
   logic        h_busy;
   logic        d_busy;
   logic        wr_ready_o;
   logic        rd_valid_o;
   logic        asleep_o;
   logic [7:0]  rd_data_o;
   logic [17:0] a;
   int          n;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   integer      seed = 21899;
   logic [7:0]  mem [int];
   logic [7:0]  rxq [$];

   always #25 clk_i = ~clk_i;

   sfm_link_if i_sfm_link_if ();
   sfm_device #(.REC_CYCLES(REC)) i_sfm_device (.clk_i(clk_i), .rstn_i(rstn_i),
      .link(i_sfm_link_if.dev), .asleep_o(asleep_o), .busy_o(d_busy));
   sfm_host #(.REC_CYCLES(REC)) i_sfm_host (.clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
      .op_i(op_i), .addr_i(addr_i), .len_i(len_i), .busy_o(h_busy), .wr_data_i(wr_data_i),
      .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
      .rd_valid_o(rd_valid_o), .link(i_sfm_link_if.host));
   sfm_link_checker i_sfm_link_checker (.clk_i(clk_i), .rstn_i(rstn_i),
      .cs_n(i_sfm_link_if.cs_n), .sck(i_sfm_link_if.sck), .so_oe_n(i_sfm_link_if.so_oe_n),
      .asleep_o(asleep_o));

   // sampled mid-cycle, away from the edge that launches the pulse
   always @(negedge clk_i) begin
      if (rd_valid_o === 1'b1) begin
         rxq.push_back(rd_data_o);
      end
   end

   task automatic conclude;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         errors++;
         conclude();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // expected identify sequence: continuation, maker, product
   function automatic logic [7:0] id_byte(input int i);
      if (i < 6) return ID_CONT;
      if (i == 6) return ID_MAKER;
      if (i == 7) return {ID_FAMILY, ID_DENSITY};
      return {ID_SUB, ID_REV, ID_RSVD};
   endfunction

   function automatic logic [7:0] exp_byte(input logic [7:0] op, input logic [17:0] ad,
                                           input int i);
      if (op == OP_IDENTIFY) return id_byte(i);
      if (op == OP_READ || op == OP_LAT_READ) return mem[(int'(ad) + i) % DEPTH_BYTES];
      // released line reads as the pull-up level
      return 8'hFF;
   endfunction

   task automatic cmd(input logic [7:0] op, input logic [17:0] ad, input int len);
      int k;
      @(negedge clk_i);
      start_i = 1'b1;
      op_i = op;
      addr_i = ad;
      len_i = 16'(len);
      @(negedge clk_i);
      start_i = 1'b0;
      k = 0;
      while (h_busy !== 1'b0 && k < 8000) begin
         @(negedge clk_i);
         k++;
      end
   endtask

   // preload the write buffer, one byte per accepted cycle
   task automatic fill(input logic [17:0] ad, input int len);
      int k;
      @(negedge clk_i);
      for (int i = 0; i < len; i++) begin
         k = 0;
         while (wr_ready_o !== 1'b1 && k < 100) begin
            @(negedge clk_i);
            k++;
         end
         wr_data_i = 8'($random(seed));
         mem[(int'(ad) + i) % DEPTH_BYTES] = wr_data_i;
         wr_valid_i = 1'b1;
         @(negedge clk_i);
      end
      wr_valid_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] op, input logic [17:0] ad, input int len);
      rxq.delete();
      cmd(op, ad, len);
      check(8'(rxq.size()), 8'(len));
      check({7'h00, d_busy}, 8'h00);
      foreach (rxq[i]) check(rxq[i], exp_byte(op, ad, i));
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      rstn_i = 1'b1;
      rd(OP_IDENTIFY, 18'h00000, 9);
      fill(18'h3FFF8, 16);
      @(negedge clk_i);
      check({7'h00, wr_ready_o}, 8'h00);
      cmd(OP_WRITE, 18'h3FFF8, 16);
      rd(OP_READ, 18'h3FFF8, 16);
      rd(OP_LAT_READ, 18'h3FFFC, 8);
      rd(8'h55, 18'h00010, 2);
      cmd(OP_SLEEP, 18'h00000, 0);
      repeat (8) @(negedge clk_i);
      check({7'h00, asleep_o}, 8'h01);
      rd(OP_READ, 18'h00000, 4);
      check({7'h00, asleep_o}, 8'h00);
      for (int r = 0; r < 6; r++) begin
         a = 18'($random(seed));
         n = 1 + int'({$random(seed)} % 6);
         fill(a, n);
         cmd(OP_WRITE, a, n);
         rd(r[0] ? OP_LAT_READ : OP_READ, a, n);
      end
      conclude();
   end
endmodule
`default_nettype wire
